// ===== verilog/ssc_pkg.sv
package ssc_pkg;

  // Module address: fixed upper five bits, selectable low two bits
  localparam logic [4:0] ADDR_FIXED      = 5'h18;
  localparam logic [1:0] ADDR_ALWAYS_OK  = 2'h1;

  // Bits in one byte, counted on the serial clock
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [3:0] FIRST_BIT_SENT  = 4'h1;

  // Write byte slots after the address byte
  localparam logic [1:0] SLOT_DIV_HIGH   = 2'h0;
  localparam logic [1:0] SLOT_DIV_LOW    = 2'h1;
  localparam logic [1:0] SLOT_CONTROL    = 2'h2;
  localparam logic [1:0] SLOT_PORT       = 2'h3;
  localparam int         SLOT_FLAG_BIT   = 7;

  // Status byte fields
  localparam int         STAT_POR_BIT    = 7;
  localparam int         STAT_LOCK_BIT   = 6;
  localparam logic [2:0] STAT_ZERO_FIELD = 3'h0;

  // Band output levels
  localparam logic [1:0] BAND_LOWEST     = 2'h0;
  localparam logic [1:0] BAND_MID        = 2'h1;
  localparam logic [1:0] BAND_HIGH       = 2'h2;
  localparam logic [1:0] BAND_SUPPLY     = 2'h3;

  // Follower port patterns {c, b, a} in port-source band mode
  localparam logic [2:0] FOL_PAT_LOWEST  = 3'h6;
  localparam logic [2:0] FOL_PAT_MID     = 3'h5;
  localparam logic [2:0] FOL_PAT_HIGH    = 3'h3;

  // Values after power-on
  localparam logic [14:0] DIVIDER_RESET  = 15'h0000;
  localparam logic        POR_RESET      = 1'b1;

  // Synchroniser depth for every pin input
  localparam int         SYNC_STAGES     = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK,
    ST_SKIP
  } ssc_state_e;

  // Control byte, bits 6..0
  typedef struct packed {
    logic       pump_current_select;
    logic       test_route_bit;
    logic       pump_tristate_bit;
    logic       band_source_select;
    logic [1:0] band_code_bits;
    logic       amp_off_bit;
  } ssc_ctrl_s;

  // Port byte, bits 7..0
  typedef struct packed {
    logic follower_port_c;
    logic adc_shared_port;
    logic follower_port_b;
    logic follower_port_a;
    logic unused_bit;
    logic collector_port_c;
    logic collector_port_b;
    logic collector_port_a;
  } ssc_port_s;

  localparam ssc_ctrl_s CTRL_RESET = '0;
  localparam ssc_port_s PORT_RESET = '0;

endpackage : ssc_pkg

// ===== verilog/ssc_sync.sv
`timescale 1ns/1ps

// Multi-stage synchroniser bank for pin inputs
module ssc_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = ssc_pkg::SYNC_STAGES
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_ff [STAGES];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_ff[i] <= '0;
      end
    end else begin
      stage_ff[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_ff[i] <= stage_ff[i-1];
      end
    end
  end

  assign sync_out = stage_ff[STAGES-1];

endmodule : ssc_sync

// ===== verilog/ssc_serial_port.sv
`timescale 1ns/1ps

// Summary of operation
// - First byte top bit picks divider or control
// - Auto-increment byte slots until STOP arrives
// - Power-on: collectors released, followers driven high
// - Port byte bit order fixed, bit 3 ignored
// - Pump current select: 0 low, 1 high
// - Test bit routes clocks onto two ports
// - Tristate bit floats the charge-pump output
// - Amp-off bit disables tuning amplifier drive
// - Band code bits choose band level
// - Follower patterns choose band level instead
// - Collector bit 1 sinks, 0 releases
// - Follower bit 1 forces low, 0 drives
// - Read address acknowledged, status shifted MSB first
// - Controller acknowledge repeats the status byte
// - Missing acknowledge ends read, data released
// - Status: power-on, lock, zeros, level code
// - Power flag set by reset/brown-out, read clears
// - Lock flag reports phase lock
// - Comparator levels encode into three bits
// - Address from select pin; 01 always matches
module ssc_serial_port (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [1:0]  addr_select_pin,
  input  wire logic [3:0]  adc_level_cmp,
  input  wire logic        lock_detect,
  input  wire logic        supply_low,
  input  wire logic        divided_rf_clock,
  input  wire logic        reference_clock,
  output logic [14:0]      divider_ratio,
  output logic             pump_current_high,
  output logic             pump_tristate,
  output logic             amp_off,
  output logic [1:0]       band_voltage_pin,
  output logic [2:0]       collector_oe_n,
  output logic             adc_port_oe_n,
  output logic [2:0]       follower_high
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions
  // Thermometer comparator outputs to level code
  function automatic logic [2:0] level_encode(input logic [3:0] cmp);
    logic [2:0] code;
    code = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (cmp[i]) begin
        code = 3'(i + 1);
      end
    end
    return code;
  endfunction : level_encode

  // Band level from follower bits {c, b, a}
  function automatic logic [1:0] follower_band(input logic [2:0] pat);
    logic [1:0] lvl;
    lvl = ssc_pkg::BAND_LOWEST;
    if (pat == ssc_pkg::FOL_PAT_MID) begin
      lvl = ssc_pkg::BAND_MID;
    end else if (pat == ssc_pkg::FOL_PAT_HIGH) begin
      lvl = ssc_pkg::BAND_HIGH;
    end
    return lvl;
  endfunction : follower_band

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int SW = 12;

  logic [SW-1:0] raw_async;
  logic [SW-1:0] sync_q;
  logic          scl_s;
  logic          sda_s;
  logic [1:0]    addr_sel_s;
  logic [3:0]    adc_cmp_s;
  logic          lock_s;
  logic          supply_low_s;
  logic          div_clk_s;
  logic          ref_clk_s;

  assign raw_async = {scl_in, sda_in, addr_select_pin, adc_level_cmp,
                      lock_detect, supply_low, divided_rf_clock, reference_clock};

  ssc_sync #(
    .WIDTH  (SW),
    .STAGES (ssc_pkg::SYNC_STAGES)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (raw_async),
    .sync_out (sync_q)
  );

  assign {scl_s, sda_s, addr_sel_s, adc_cmp_s,
          lock_s, supply_low_s, div_clk_s, ref_clk_s} = sync_q;

  //////////////////////////////////////////////////////////////////////////////
  // Bus condition detection
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_d_ff;
  assign scl_fall   = ~scl_s & scl_d_ff;
  assign start_cond = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_cond  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  //////////////////////////////////////////////////////////////////////////////
  // Status byte and address match
  logic       por_ff;
  logic [7:0] status_readback;
  logic       addr_hit;

  always_comb begin
    status_readback                     = '0;
    status_readback[ssc_pkg::STAT_POR_BIT]  = por_ff;
    status_readback[ssc_pkg::STAT_LOCK_BIT] = lock_s;
    status_readback[5:3]                = ssc_pkg::STAT_ZERO_FIELD;
    status_readback[2:0]                = level_encode(adc_cmp_s);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial protocol engine
  ssc_pkg::ssc_state_e state_ff;
  logic [3:0]          bit_cnt_ff;
  logic [7:0]          shift_ff;
  logic                is_read_ff;
  logic                master_ack_ff;
  logic                sda_drive_ff;

  assign addr_hit = (shift_ff[7:3] == ssc_pkg::ADDR_FIXED) &&
                    ((shift_ff[2:1] == addr_sel_s) ||
                     (shift_ff[2:1] == ssc_pkg::ADDR_ALWAYS_OK));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= ssc_pkg::ST_IDLE;
      bit_cnt_ff    <= '0;
      shift_ff      <= '0;
      is_read_ff    <= 1'b0;
      master_ack_ff <= 1'b0;
      sda_drive_ff  <= 1'b0;
    end else if (start_cond) begin
      state_ff     <= ssc_pkg::ST_ADDR;
      bit_cnt_ff   <= '0;
      sda_drive_ff <= 1'b0;
    end else if (stop_cond) begin
      state_ff     <= ssc_pkg::ST_IDLE;
      sda_drive_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ssc_pkg::ST_IDLE, ssc_pkg::ST_SKIP: begin
          sda_drive_ff <= 1'b0;
        end
        ssc_pkg::ST_ADDR, ssc_pkg::ST_WR_DATA: begin
          if (scl_rise) begin
            shift_ff   <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == ssc_pkg::BYTE_BITS) begin
            bit_cnt_ff <= '0;
            if (state_ff == ssc_pkg::ST_WR_DATA) begin
              sda_drive_ff <= 1'b1;
              state_ff     <= ssc_pkg::ST_WR_ACK;
            end else if (addr_hit) begin
              sda_drive_ff <= 1'b1;
              is_read_ff   <= shift_ff[0];
              state_ff     <= ssc_pkg::ST_ADDR_ACK;
            end else begin
              state_ff <= ssc_pkg::ST_SKIP;
            end
          end
        end
        ssc_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (is_read_ff) begin
              shift_ff     <= status_readback;
              sda_drive_ff <= ~status_readback[7];
              bit_cnt_ff   <= ssc_pkg::FIRST_BIT_SENT;
              state_ff     <= ssc_pkg::ST_RD_DATA;
            end else begin
              sda_drive_ff <= 1'b0;
              state_ff     <= ssc_pkg::ST_WR_DATA;
            end
          end
        end
        ssc_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            sda_drive_ff <= 1'b0;
            state_ff     <= ssc_pkg::ST_WR_DATA;
          end
        end
        ssc_pkg::ST_RD_DATA: begin
          if (scl_fall) begin
            if (bit_cnt_ff == ssc_pkg::BYTE_BITS) begin
              sda_drive_ff <= 1'b0;
              state_ff     <= ssc_pkg::ST_RD_ACK;
            end else begin
              sda_drive_ff <= ~shift_ff[6];
              shift_ff     <= {shift_ff[6:0], 1'b0};
              bit_cnt_ff   <= bit_cnt_ff + 4'h1;
            end
          end
        end
        ssc_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            master_ack_ff <= ~sda_s;
          end else if (scl_fall) begin
            if (master_ack_ff) begin
              shift_ff     <= status_readback;
              sda_drive_ff <= ~status_readback[7];
              bit_cnt_ff   <= ssc_pkg::FIRST_BIT_SENT;
              state_ff     <= ssc_pkg::ST_RD_DATA;
            end else begin
              sda_drive_ff <= 1'b0;
              state_ff     <= ssc_pkg::ST_SKIP;
            end
          end
        end
      endcase
    end
  end

  // Open-drain data line: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~sda_drive_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Power-on flag
  logic read_done;

  // End of read: missing acknowledge, or a bus condition cutting a read short
  assign read_done = ((state_ff == ssc_pkg::ST_RD_ACK) && scl_fall &&
                      !master_ack_ff && !start_cond && !stop_cond) ||
                     ((start_cond || stop_cond) &&
                      ((state_ff == ssc_pkg::ST_RD_DATA) ||
                       (state_ff == ssc_pkg::ST_RD_ACK)));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      por_ff <= ssc_pkg::POR_RESET;
    end else if (supply_low_s) begin
      por_ff <= 1'b1;
    end else if (read_done) begin
      por_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write slot sequencing
  logic       wr_byte_done;
  logic       first_ff;
  logic [1:0] slot_ff;
  logic [1:0] slot_now;

  assign wr_byte_done = (state_ff == ssc_pkg::ST_WR_DATA) && scl_fall &&
                        (bit_cnt_ff == ssc_pkg::BYTE_BITS) &&
                        !start_cond && !stop_cond;

  // A leading byte picks its slot from the flag bit
  assign slot_now = !first_ff ? slot_ff :
                    shift_ff[ssc_pkg::SLOT_FLAG_BIT] ? ssc_pkg::SLOT_CONTROL
                                                     : ssc_pkg::SLOT_DIV_HIGH;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      first_ff <= 1'b1;
      slot_ff  <= ssc_pkg::SLOT_DIV_HIGH;
    end else if (state_ff == ssc_pkg::ST_ADDR_ACK) begin
      first_ff <= 1'b1;
    end else if (wr_byte_done) begin
      slot_ff  <= slot_now + 2'h1;
      first_ff <= (slot_now == ssc_pkg::SLOT_PORT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Programmed registers
  logic [14:0]        divider_ff;
  ssc_pkg::ssc_ctrl_s ctrl_ff;
  ssc_pkg::ssc_port_s port_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divider_ff <= ssc_pkg::DIVIDER_RESET;
      ctrl_ff    <= ssc_pkg::CTRL_RESET;
      port_ff    <= ssc_pkg::PORT_RESET;
    end else if (wr_byte_done) begin
      unique case (slot_now)
        ssc_pkg::SLOT_DIV_HIGH: divider_ff[14:8] <= shift_ff[6:0];
        ssc_pkg::SLOT_DIV_LOW:  divider_ff[7:0]  <= shift_ff;
        ssc_pkg::SLOT_CONTROL:  ctrl_ff <= ssc_pkg::ssc_ctrl_s'(shift_ff[6:0]);
        ssc_pkg::SLOT_PORT:     port_ff <= ssc_pkg::ssc_port_s'(shift_ff);
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output drivers
  logic [1:0] band_ff;
  logic [2:0] collector_oe_n_ff;
  logic       adc_port_oe_n_ff;
  logic [2:0] follower_high_ff;
  logic [2:0] fol_bits;

  assign fol_bits = {port_ff.follower_port_c, port_ff.follower_port_b,
                     port_ff.follower_port_a};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      band_ff <= ssc_pkg::BAND_LOWEST;
    end else if (ctrl_ff.band_source_select) begin
      band_ff <= follower_band(fol_bits);
    end else begin
      band_ff <= ctrl_ff.band_code_bits;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      collector_oe_n_ff <= 3'h7;
      adc_port_oe_n_ff  <= 1'b1;
      follower_high_ff  <= 3'h7;
    end else begin
      collector_oe_n_ff[0] <= ~port_ff.collector_port_a;
      collector_oe_n_ff[1] <= ~port_ff.collector_port_b;
      if (ctrl_ff.test_route_bit) begin
        collector_oe_n_ff[2] <= div_clk_s;
        adc_port_oe_n_ff     <= ref_clk_s;
      end else begin
        collector_oe_n_ff[2] <= ~port_ff.collector_port_c;
        adc_port_oe_n_ff     <= ~port_ff.adc_shared_port;
      end
      follower_high_ff <= ~fol_bits;
    end
  end

  assign divider_ratio     = divider_ff;
  assign pump_current_high = ctrl_ff.pump_current_select;
  assign pump_tristate     = ctrl_ff.pump_tristate_bit;
  assign amp_off           = ctrl_ff.amp_off_bit;
  assign band_voltage_pin  = band_ff;
  assign collector_oe_n    = collector_oe_n_ff;
  assign adc_port_oe_n     = adc_port_oe_n_ff;
  assign follower_high     = follower_high_ff;

endmodule : ssc_serial_port

// ===== test/ssc_bus_ctrl.sv
`timescale 1ns/1ps

// Two-wire bus controller; quarter-bit steps give a 160 ns serial clock
module ssc_bus_ctrl (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  localparam time QTR = 40ns;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start_cond;
    sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask : start_cond

  task automatic stop_cond;
    sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0;
    #(2 * QTR);
  endtask : stop_cond

  // Data set mid-low, sampled mid-high, clock idles high between frames
  task automatic one_bit(input logic v, output logic seen);
    sda_low = ~v;
    #QTR scl = 1'b1;
    #QTR seen = sda_line;
    #QTR scl = 1'b0;
    #QTR;
  endtask : one_bit

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(d[i], s);
    end
    one_bit(1'b1, s);
    ack = ~s;
  endtask : write_byte

  task automatic read_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(1'b1, s);
      d[i] = s;
    end
    one_bit(~give_ack, s);
  endtask : read_byte
endmodule : ssc_bus_ctrl

// ===== test/ssc_serial_port_asserts.sv
`timescale 1ns/1ps

module ssc_serial_port_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic [14:0] divider_ratio,
  input wire logic        pump_current_high,
  input wire logic        pump_tristate,
  input wire logic        amp_off,
  input wire logic [1:0]  band_voltage_pin,
  input wire logic [2:0]  collector_oe_n,
  input wire logic        adc_port_oe_n,
  input wire logic [2:0]  follower_high
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  sda_open_drain_a: assert property (sda_out == 1'b0)
    else $error("data pin output not low");
  sda_edge_a: assert property ($changed(sda_oe_n)
    |-> !scl_in && !$past(scl_in) && !$past(scl_in, 2))
    else $error("data pin changed near clock high");
  sda_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*4])
    else $error("data pin pulled low too briefly");
  reset_ports_a: assert property ($rose(rst_n) |-> collector_oe_n == 3'h7
    && adc_port_oe_n && follower_high == 3'h7 && sda_oe_n)
    else $error("ports not released after reset");

  ////////////////////////////////////////////////////////////////////////////////
  // Stored bits change only around a device acknowledge
  divider_on_ack_a: assert property ($changed(divider_ratio) |-> ##[0:4] !sda_oe_n)
    else $error("divider changed outside acknowledge");
  pump_on_ack_a: assert property ($changed(pump_current_high) |-> ##[0:4] !sda_oe_n)
    else $error("pump current changed outside acknowledge");
  tristate_on_ack_a: assert property ($changed(pump_tristate) |-> ##[0:4] !sda_oe_n)
    else $error("pump tristate changed outside acknowledge");
  amp_on_ack_a: assert property ($changed(amp_off) |-> ##[0:4] !sda_oe_n)
    else $error("amplifier bit changed outside acknowledge");
  band_on_ack_a: assert property ($changed(band_voltage_pin) |-> ##[0:4] !sda_oe_n)
    else $error("band level changed outside acknowledge");
  collector_on_ack_a: assert property ($changed(collector_oe_n[1:0]) |-> ##[0:4] !sda_oe_n)
    else $error("collector port changed outside acknowledge");
  follower_on_ack_a: assert property ($changed(follower_high) |-> ##[0:4] !sda_oe_n)
    else $error("follower port changed outside acknowledge");

  ack_seen_c: cover property ($fell(sda_oe_n));
  divider_set_c: cover property ($changed(divider_ratio));
  band_set_c: cover property ($changed(band_voltage_pin));
endmodule : ssc_serial_port_asserts

// ===== test/synth_serial_control_port_bench.sv
`timescale 1ns/1ps

module synth_serial_control_port_bench;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] port;
    logic [1:0] band;
  } ssc_row_s;

  logic        clk_sys;
  logic        rst_n;
  logic        scl_in;
  logic        sda_in;
  logic        sda_low;
  logic [1:0]  addr_select_pin;
  logic [3:0]  adc_level_cmp;
  logic        lock_detect;
  logic        supply_low;
  logic        divided_rf_clock;
  logic        reference_clock;
  logic        sda_out;
  logic        sda_oe_n;
  logic [14:0] divider_ratio;
  logic        pump_current_high;
  logic        pump_tristate;
  logic        amp_off;
  logic [1:0]  band_voltage_pin;
  logic [2:0]  collector_oe_n;
  logic        adc_port_oe_n;
  logic [2:0]  follower_high;
  int          err_total;
  int          check_count;
  int          n;
  logic        ack;
  logic [7:0]  adr [5] = '{8'hC4, 8'hC2, 8'hC6, 8'hC0, 8'h84};
  ssc_row_s    rows [8] = '{
    '{8'h80, 8'h08, 2'h0}, '{8'hC2, 8'h07, 2'h1}, '{8'h94, 8'h40, 2'h2}, '{8'h87, 8'h05, 2'h3},
    '{8'h88, 8'hA0, 2'h0}, '{8'h88, 8'h90, 2'h1}, '{8'h88, 8'h30, 2'h2}, '{8'h8E, 8'hB0, 2'h0}};

  // Pulled-up data wire
  assign sda_in = (sda_low || !sda_oe_n) ? 1'b0 : 1'b1;

  ssc_bus_ctrl ctl (.scl(scl_in), .sda_low(sda_low), .sda_line(sda_in));

  ssc_serial_port dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_pin(addr_select_pin),
    .adc_level_cmp(adc_level_cmp), .lock_detect(lock_detect), .supply_low(supply_low),
    .divided_rf_clock(divided_rf_clock), .reference_clock(reference_clock),
    .divider_ratio(divider_ratio), .pump_current_high(pump_current_high),
    .pump_tristate(pump_tristate), .amp_off(amp_off), .band_voltage_pin(band_voltage_pin),
    .collector_oe_n(collector_oe_n), .adc_port_oe_n(adc_port_oe_n),
    .follower_high(follower_high));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] got_v, input logic [15:0] exp_v);
    check_count++;
    if (got_v !== exp_v) begin
      $display("mismatch %s expected %h seen %h", what, exp_v, got_v);
      err_total++;
    end
  endtask : check

  task automatic wr(input logic [7:0] bytes [$]);
    logic a;
    ctl.start_cond();
    foreach (bytes[i]) begin
      ctl.write_byte(bytes[i], a);
      check("write ack", 16'(a), 16'h1);
    end
    ctl.stop_cond();
  endtask : wr

  task automatic rd(input logic por, input logic [2:0] lvl, input int cnt);
    logic a;
    logic [7:0] d;
    ctl.start_cond();
    ctl.write_byte(8'hC3, a);
    check("read ack", 16'(a), 16'h1);
    for (int i = 0; i < cnt; i++) begin
      ctl.read_byte(i < cnt - 1, d);
      check("status", 16'(d), 16'({por, lock_detect, 3'h0, lvl}));
    end
    repeat (4) @(posedge clk_sys);
    #1;
    check("release", 16'(sda_oe_n), 16'h1);
    ctl.stop_cond();
  endtask : rd

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    check_count = 0;
    rst_n = 1'b0;
    addr_select_pin = 2'h1;
    adc_level_cmp = 4'h0;
    lock_detect = 1'b1;
    supply_low = 1'b0;
    divided_rf_clock = 1'b1;
    reference_clock = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    check("collector", 16'(collector_oe_n), 16'h7);
    check("shared", 16'(adc_port_oe_n), 16'h1);
    check("follower", 16'(follower_high), 16'h7);
    $display("reset test done");
    foreach (rows[i]) begin
      wr({8'hC2, rows[i].ctrl, rows[i].port});
      check("band", 16'(band_voltage_pin), 16'(rows[i].band));
      check("pump", 16'(pump_current_high), 16'(rows[i].ctrl[6]));
      check("tristate", 16'(pump_tristate), 16'(rows[i].ctrl[4]));
      check("amp", 16'(amp_off), 16'(rows[i].ctrl[0]));
      check("collector", 16'(collector_oe_n), 16'(rows[i].port[2:0] ^ 3'h7));
      check("shared", 16'(adc_port_oe_n), 16'(rows[i].port[6] ^ 1'b1));
      check("follower", 16'(follower_high), 16'({rows[i].port[7], rows[i].port[5:4]} ^ 3'h7));
      $display("row %0d test done", i);
    end
    wr({8'hC2, 8'h12, 8'h34, 8'h80, 8'h00, 8'h05, 8'h67});
    check("divider", 16'(divider_ratio), 16'h0567);
    wr({8'hC2, 8'h7F, 8'hFF});
    check("divider", 16'(divider_ratio), 16'h7FFF);
    wr({8'hC2, 8'h00});
    check("divider", 16'(divider_ratio), 16'h00FF);
    $display("divider test done");
    addr_select_pin = 2'h2;
    foreach (adr[i]) begin
      ctl.start_cond();
      ctl.write_byte(adr[i], ack);
      ctl.stop_cond();
      check("address ack", 16'(ack), 16'(i < 2));
    end
    $display("address test done");
    wr({8'hC2, 8'h80, 8'h00});
    rd(1'b1, 3'h0, 2);
    for (n = 0; n < 5; n++) begin
      adc_level_cmp = 4'((1 << n) - 1);
      lock_detect = n[0];
      rd(1'b0, 3'(n), 1);
    end
    supply_low = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 supply_low = 1'b0;
    rd(1'b1, 3'h4, 1);
    rd(1'b0, 3'h4, 1);
    $display("read test done");
    wr({8'hC2, 8'hA0, 8'h00});
    divided_rf_clock = 1'b0;
    reference_clock = 1'b0;
    for (n = 0; n < 10 && collector_oe_n[2] !== 1'b0; n++) @(posedge clk_sys);
    #1;
    check("routed divider", 16'(collector_oe_n[2]), 16'h0);
    check("routed reference", 16'(adc_port_oe_n), 16'h0);
    divided_rf_clock = 1'b1;
    reference_clock = 1'b1;
    for (n = 0; n < 10 && collector_oe_n[2] !== 1'b1; n++) @(posedge clk_sys);
    #1;
    check("routed divider", 16'(collector_oe_n[2]), 16'h1);
    check("routed reference", 16'(adc_port_oe_n), 16'h1);
    $display("test route done");
    complete_run();
  end

  initial begin
    #1ms;
    $display("timeout reached");
    err_total++;
    complete_run();
  end
endmodule : synth_serial_control_port_bench

bind ssc_serial_port ssc_serial_port_asserts chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .divider_ratio(divider_ratio), .pump_current_high(pump_current_high),
  .pump_tristate(pump_tristate), .amp_off(amp_off), .band_voltage_pin(band_voltage_pin),
  .collector_oe_n(collector_oe_n), .adc_port_oe_n(adc_port_oe_n),
  .follower_high(follower_high));
